// File: addr_gen_cfg.svh
// Constants for the effective-address generator and stack checker.
`ifndef ADDR_GEN_CFG_SVH
`define ADDR_GEN_CFG_SVH
`define SP_IDX 4'hF
`define DEFAULT_WORKING_REG_IDX 4'h0
`define XPA_IDX 4'h8
`define XPB_IDX 4'h9
`define YPA_IDX 4'hA
`define YPB_IDX 4'hB
`define SP_RESET 16'h0800
`define SP_FLOOR 16'h0800
`define WORD_STEP 16'h0002
`define MAC_STEP4 16'h0004
`define MAC_STEP6 16'h0006
`define LIMIT_MASK 16'hFFFE
`define ZERO16 16'h0000
`define ZERO8 8'h00
`define NUM_WREGS 16
`define FILE_MSB 12
`define LIT5_MSB 4
`define LIT8_MSB 7
`define LIT10_MSB 9
`define LIT14_MSB 13
`define PC_MSB 22
`define PC_HI_LSB 16
`endif

// File: addr_gen_pkg.sv
// Types shared by the effective-address generator and its partners.
package addr_gen_pkg;
   typedef enum logic [4:0] {
      AM_NONE, AM_FILE, AM_MOVFILE, AM_DIRECT, AM_IND, AM_POST, AM_PRE,
      AM_INDEXED, AM_LITOFS, AM_LIT5, AM_LIT8, AM_LIT10, AM_LIT16,
      AM_BRA, AM_INTERRUPT_DISABLE_INSTRUCTION, AM_PUSH, AM_POP, AM_CALL_PUSH, AM_EXC_PUSH, AM_MAC
   } agen_mode_t;
   typedef enum logic [2:0] {MM_NONE, MM_IND, MM_P2, MM_P4, MM_P6, MM_IDX} mac_mod_t;
   typedef struct packed {
      logic valid;
      agen_mode_t mode;
      logic [3:0] ptr;
      logic [3:0] ofs;
      logic [15:0] lit;
      logic to_default_working_reg;
      logic [3:0] dst;
      logic x_sel;
      logic y_sel;
      mac_mod_t x_mod;
      mac_mod_t y_mod;
   } agen_req_t;
   typedef struct packed {
      logic ea_valid;
      logic [15:0] ea;
      logic [15:0] opnd;
      logic opnd_valid;
      logic [15:0] base;
      logic [3:0] dst;
      logic [15:0] push_data;
      logic upd_we;
      logic [3:0] upd_idx;
      logic [15:0] upd_val;
      logic x_valid;
      logic [15:0] x_ea;
      logic y_valid;
      logic [15:0] y_ea;
   } agen_rsp_t;
endpackage : addr_gen_pkg

// File: addr_gen_stack_check.sv
// Effective-address generation with software-stack limit and floor checking.
`timescale 1ns/1ps
`include "addr_gen_cfg.svh"

module addr_gen_stack_check (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Decoded instruction request
   input wire addr_gen_pkg::agen_req_t req,
   input wire logic [`PC_MSB:0] pc,
   input wire logic [7:0] status_low_byte,
   // Core writeback into the working registers
   input wire logic wr_we,
   input wire logic [3:0] wr_idx,
   input wire logic [15:0] wr_data,
   // Stack limit register write
   input wire logic limit_we,
   input wire logic [15:0] limit_data,
   // Results to data memory and decode
   output addr_gen_pkg::agen_rsp_t rsp,
   output logic [15:0] stack_limit_reg,
   output logic [15:0] stack_pointer_reg,
   // Trap request to exception logic
   output logic stack_trap
);

   // Working register file; the stack pointer is simply its last entry.
   logic [15:0] regs_ff [`NUM_WREGS];
   logic [15:0] nxt_regs [`NUM_WREGS];
   logic [15:0] limit_ff;
   logic [15:0] nxt_limit;
   addr_gen_pkg::agen_rsp_t rsp_ff;
   addr_gen_pkg::agen_rsp_t nxt_rsp;
   logic trap_ff;
   logic nxt_trap;
   // Operand values read from the register file this cycle.
   logic [15:0] ptr_val;
   logic [15:0] ofs_val;
   logic [15:0] sp_val;
   logic [3:0] ea_ptr;
   logic [3:0] xp;
   logic [3:0] yp;
   logic [15:0] x_step;
   logic [15:0] y_step;
   logic stack_hit;
   logic over_limit;
   logic under_floor;

   // Limit register: software data, deliberately left without reset.
   // Bit zero is masked on the way in because stack words are always aligned.
   always_comb begin
      nxt_limit = limit_ff;
      if (limit_we) begin
         nxt_limit = limit_data & `LIMIT_MASK;
      end
   end

   // An unknown limit only matters once the stack is used, so write it first.
   always_ff @(posedge clk) begin
      limit_ff <= nxt_limit;
   end

   // Step size for a MAC prefetch post-modification.
   // Indirect and indexed prefetches leave the pointer where it is.
   function automatic logic [15:0] mac_step(input addr_gen_pkg::mac_mod_t m);
      case (m)
         addr_gen_pkg::MM_P2: mac_step = `WORD_STEP;
         addr_gen_pkg::MM_P4: mac_step = `MAC_STEP4;
         addr_gen_pkg::MM_P6: mac_step = `MAC_STEP6;
         default: mac_step = `ZERO16;
      endcase
   endfunction : mac_step

   // Address formation, pointer updates and stack checking.
   always_comb begin
      nxt_regs = regs_ff;
      nxt_rsp = '0;
      ea_ptr = req.ptr;
      ptr_val = regs_ff[req.ptr];
      ofs_val = regs_ff[req.ofs];
      sp_val = regs_ff[`SP_IDX];
      xp = req.x_sel ? `XPB_IDX : `XPA_IDX;
      yp = req.y_sel ? `YPB_IDX : `YPA_IDX;
      x_step = mac_step(req.x_mod);
      y_step = mac_step(req.y_mod);
      // Core writeback goes in first so that an address update in the same cycle wins.
      if (wr_we) begin
         nxt_regs[wr_idx] = wr_data;
      end
      if (req.valid) begin
         // The base register value travels with every request for three-operand forms.
         nxt_rsp.base = ofs_val;
         nxt_rsp.dst = req.to_default_working_reg ? `DEFAULT_WORKING_REG_IDX : req.dst;
         case (req.mode)
            addr_gen_pkg::AM_FILE: begin
               // Near space only; the move form below reaches the whole data space.
               nxt_rsp.ea_valid = 1'b1;
               nxt_rsp.ea = 16'(req.lit[`FILE_MSB:0]);
               ea_ptr = `DEFAULT_WORKING_REG_IDX;
            end
            addr_gen_pkg::AM_MOVFILE: begin
               nxt_rsp.ea_valid = 1'b1;
               nxt_rsp.ea = req.lit;
               ea_ptr = `DEFAULT_WORKING_REG_IDX;
            end
            addr_gen_pkg::AM_DIRECT: begin
               nxt_rsp.opnd_valid = 1'b1;
               nxt_rsp.opnd = ptr_val;
            end
            addr_gen_pkg::AM_IND: begin
               nxt_rsp.ea_valid = 1'b1;
               nxt_rsp.ea = ptr_val;
            end
            addr_gen_pkg::AM_POST: begin
               nxt_rsp.ea_valid = 1'b1;
               nxt_rsp.ea = ptr_val;
               nxt_rsp.upd_we = 1'b1;
               nxt_rsp.upd_idx = req.ptr;
               nxt_rsp.upd_val = ptr_val + req.lit;
            end
            addr_gen_pkg::AM_PRE: begin
               // The literal is signed, so the pointer may move either way.
               nxt_rsp.ea_valid = 1'b1;
               nxt_rsp.ea = ptr_val + req.lit;
               nxt_rsp.upd_we = 1'b1;
               nxt_rsp.upd_idx = req.ptr;
               nxt_rsp.upd_val = ptr_val + req.lit;
            end
            addr_gen_pkg::AM_INDEXED: begin
               nxt_rsp.ea_valid = 1'b1;
               nxt_rsp.ea = ptr_val + ofs_val;
            end
            addr_gen_pkg::AM_LITOFS: begin
               nxt_rsp.ea_valid = 1'b1;
               nxt_rsp.ea = ptr_val + req.lit;
            end
            // Literal operands are zero-extended; only the branch literal keeps its sign.
            addr_gen_pkg::AM_LIT5: begin
               nxt_rsp.opnd_valid = 1'b1;
               nxt_rsp.opnd = 16'(req.lit[`LIT5_MSB:0]);
            end
            addr_gen_pkg::AM_LIT8: begin
               nxt_rsp.opnd_valid = 1'b1;
               nxt_rsp.opnd = 16'(req.lit[`LIT8_MSB:0]);
            end
            addr_gen_pkg::AM_LIT10: begin
               nxt_rsp.opnd_valid = 1'b1;
               nxt_rsp.opnd = 16'(req.lit[`LIT10_MSB:0]);
            end
            addr_gen_pkg::AM_LIT16: begin
               nxt_rsp.opnd_valid = 1'b1;
               nxt_rsp.opnd = req.lit;
            end
            addr_gen_pkg::AM_BRA: begin
               // Passed whole; the branch unit treats it as two's complement.
               nxt_rsp.opnd_valid = 1'b1;
               nxt_rsp.opnd = req.lit;
            end
            addr_gen_pkg::AM_INTERRUPT_DISABLE_INSTRUCTION: begin
               // The interrupt-disable count is an unsigned field.
               nxt_rsp.opnd_valid = 1'b1;
               nxt_rsp.opnd = 16'(req.lit[`LIT14_MSB:0]);
            end
            addr_gen_pkg::AM_PUSH,
            addr_gen_pkg::AM_CALL_PUSH,
            addr_gen_pkg::AM_EXC_PUSH: begin
               // Push writes at the pointer, which then moves to the next free word.
               ea_ptr = `SP_IDX;
               nxt_rsp.ea_valid = 1'b1;
               nxt_rsp.ea = sp_val;
               nxt_rsp.upd_we = 1'b1;
               nxt_rsp.upd_idx = `SP_IDX;
               nxt_rsp.upd_val = sp_val + `WORD_STEP;
               if (req.mode == addr_gen_pkg::AM_CALL_PUSH) begin
                  nxt_rsp.push_data = {`ZERO8, 8'(pc[`PC_MSB:`PC_HI_LSB])};
               end else if (req.mode == addr_gen_pkg::AM_EXC_PUSH) begin
                  nxt_rsp.push_data = {status_low_byte, 8'(pc[`PC_MSB:`PC_HI_LSB])};
               end else begin
                  nxt_rsp.push_data = ofs_val;
               end
            end
            addr_gen_pkg::AM_POP: begin
               // Pop reads the last used word, one below the pointer.
               ea_ptr = `SP_IDX;
               nxt_rsp.ea_valid = 1'b1;
               nxt_rsp.ea = sp_val - `WORD_STEP;
               nxt_rsp.upd_we = 1'b1;
               nxt_rsp.upd_idx = `SP_IDX;
               nxt_rsp.upd_val = sp_val - `WORD_STEP;
            end
            addr_gen_pkg::AM_MAC: begin
               // Indexed prefetch exists only on the second pointer of each space.
               if (req.x_mod != addr_gen_pkg::MM_NONE) begin
                  nxt_rsp.x_valid = 1'b1;
                  nxt_rsp.x_ea = regs_ff[xp];
                  if (req.x_mod == addr_gen_pkg::MM_IDX && xp == `XPB_IDX) begin
                     nxt_rsp.x_ea = regs_ff[xp] + ofs_val;
                  end
                  nxt_regs[xp] = regs_ff[xp] + x_step;
               end
               // The Y side mirrors the X side with its own pair of pointers.
               if (req.y_mod != addr_gen_pkg::MM_NONE) begin
                  nxt_rsp.y_valid = 1'b1;
                  nxt_rsp.y_ea = regs_ff[yp];
                  if (req.y_mod == addr_gen_pkg::MM_IDX && yp == `YPB_IDX) begin
                     nxt_rsp.y_ea = regs_ff[yp] + ofs_val;
                  end
                  nxt_regs[yp] = regs_ff[yp] + y_step;
               end
            end
            // Requests in no listed mode form no address; the response carries only base and dst.
            default: begin
               nxt_rsp.ea_valid = 1'b0;
            end
         endcase
         if (nxt_rsp.upd_we) begin
            nxt_regs[nxt_rsp.upd_idx] = nxt_rsp.upd_val;
         end
      end
   end

   // Stack check: every address formed through the stack pointer is tested,
   // pushes, pops and plain indirect accesses alike.
   // Equality with the limit passes so the word at the limit still fits;
   // the push after that one is the first to trap.
   // The registered limit is used, so a write in the same cycle is not yet seen.
   always_comb begin
      stack_hit = nxt_rsp.ea_valid && (ea_ptr == `SP_IDX);
      over_limit = nxt_rsp.ea > limit_ff;
      under_floor = nxt_rsp.ea < `SP_FLOOR;
      nxt_trap = 1'b0;
      if (stack_hit) begin
         nxt_trap = over_limit || under_floor;
      end
   end

   // Every working register clears and the stack pointer starts at the floor.
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < `NUM_WREGS; i++) begin
            regs_ff[i] <= `ZERO16;
         end
         regs_ff[`SP_IDX] <= `SP_RESET;
         rsp_ff <= '0;
         trap_ff <= 1'b0;
      end else begin
         regs_ff <= nxt_regs;
         rsp_ff <= nxt_rsp;
         trap_ff <= nxt_trap;
      end
   end

   // Pointer and limit copies are registered for the core's use.
   logic [15:0] sp_out_ff;
   logic [15:0] lim_out_ff;
   logic [15:0] nxt_sp_out;
   logic [15:0] nxt_lim_out;

   // The copies carry this cycle's updates, so the core never sees a stale pointer.
   always_comb begin
      nxt_sp_out = nxt_regs[`SP_IDX];
      nxt_lim_out = nxt_limit;
      if (rst) begin
         nxt_sp_out = `SP_RESET;
      end
   end

   always_ff @(posedge clk) begin
      sp_out_ff <= nxt_sp_out;
      lim_out_ff <= nxt_lim_out;
   end

   // Every output is taken straight from a flip-flop.
   assign rsp = rsp_ff;
   assign stack_trap = trap_ff;
   assign stack_pointer_reg = sp_out_ff;
   assign stack_limit_reg = lim_out_ff;

endmodule : addr_gen_stack_check

// File: addr_gen_stack_check_props.sv
// Port-level assertions for the address generator and stack checker.
`timescale 1ns/1ps
module addr_gen_stack_check_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Request side
   input wire addr_gen_pkg::agen_req_t req,
   input wire logic [22:0] pc,
   input wire logic [7:0] status_low_byte,
   input wire logic limit_we,
   input wire logic [15:0] limit_data,
   // Result side
   input wire addr_gen_pkg::agen_rsp_t rsp,
   input wire logic [15:0] stack_limit_reg,
   input wire logic [15:0] stack_pointer_reg,
   input wire logic stack_trap
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic [15:0] sp;
   logic [15:0] lim;
   logic [15:0] lit;
   logic [6:0] pc_hi;
   logic vq;
   logic push_q;
   assign sp = stack_pointer_reg;
   assign lim = stack_limit_reg;
   assign lit = req.lit;
   assign pc_hi = pc[22:16];
   assign vq = req.valid;
   assign push_q = vq && req.mode == addr_gen_pkg::AM_PUSH;
   property p_limit; limit_we |=> lim == ($past(limit_data) & 16'hFFFE); endproperty
   a_limit: assert property (p_limit) else $error("limit bit 0 not cleared");
   property p_push; push_q |=> rsp.ea == $past(sp) && sp == $past(sp) + 16'h0002; endproperty
   a_push: assert property (p_push) else $error("push address or step wrong");
   property p_pop;
      vq && req.mode == addr_gen_pkg::AM_POP |=> rsp.ea == $past(sp) - 16'h0002 && sp == rsp.ea;
   endproperty
   a_pop: assert property (p_pop) else $error("pop address or step wrong");
   property p_call;
      vq && req.mode == addr_gen_pkg::AM_CALL_PUSH |=> rsp.push_data == {9'h000, $past(pc_hi)};
   endproperty
   a_call: assert property (p_call) else $error("call upper word wrong");
   property p_exc;
      vq && req.mode == addr_gen_pkg::AM_EXC_PUSH |=>
         rsp.push_data == {$past(status_low_byte), 1'h0, $past(pc_hi)};
   endproperty
   a_exc: assert property (p_exc) else $error("exception upper word wrong");
   // Equality with the limit must pass, so the compare is strictly greater.
   property p_trap;
      push_q |=> stack_trap == ($past(sp) > $past(lim) || $past(sp) < 16'h0800);
   endproperty
   a_trap: assert property (p_trap) else $error("push trap wrong");
   property p_pulse; stack_trap |-> rsp.ea_valid && $past(vq); endproperty
   a_pulse: assert property (p_pulse) else $error("trap without access");
   property p_file;
      vq && req.mode == addr_gen_pkg::AM_FILE |=> rsp.ea == ($past(lit) & 16'h1FFF);
   endproperty
   a_file: assert property (p_file) else $error("file address wrong");
   property p_default_working_reg; vq && req.to_default_working_reg |=> rsp.dst == 4'h0; endproperty
   a_default_working_reg: assert property (p_default_working_reg) else $error("implied register not zero");
   c_trap: cover property (push_q ##1 stack_trap);
   c_pop: cover property (vq && req.mode == addr_gen_pkg::AM_POP);
   c_limit: cover property (limit_we);
endmodule : addr_gen_stack_check_props

// File: core_side_model.sv
// Core-side request source that keeps the instruction stream legal.
`timescale 1ns/1ps
module core_side_model (
   // Clock
   input wire logic clk,
   // Bench command and limit write
   input wire addr_gen_pkg::agen_req_t cmd,
   input wire logic limit_we,
   // Request to the generator
   output addr_gen_pkg::agen_req_t req
);
   logic lim_seen_ff;
   always_ff @(posedge clk) lim_seen_ff <= limit_we;
   // Any request naming the stack pointer in the cycle after a limit write is dropped.
   always_comb begin
      req = cmd;
      if (lim_seen_ff && cmd.ptr == 4'hF) req.valid = 1'h0;
   end
endmodule : core_side_model

// File: test_addr_gen_stack_check.sv
// Self-checking bench for the address generator and stack checker.
`timescale 1ns/1ps
module test_addr_gen_stack_check;
   logic clk = 1'h0;
   logic rst = 1'h1;
   addr_gen_pkg::agen_req_t cmd = '0;
   addr_gen_pkg::agen_req_t req;
   addr_gen_pkg::agen_rsp_t rsp;
   logic [22:0] pc = 23'h000000;
   logic [7:0] slb = 8'h00;
   logic wr_we = 1'h0;
   logic [3:0] wr_idx = 4'h0;
   logic [15:0] wr_data = 16'h0000;
   logic limit_we = 1'h0;
   logic [15:0] limit_data = 16'h0000;
   logic [15:0] lim;
   logic [15:0] sp;
   logic trap;
   logic [15:0] w [16];
   logic [15:0] lm;
   logic [31:0] r;
   logic [15:0] stp [6] = '{16'h0000, 16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0000};
   int error_cnt = 0;
   int samples_checked = 0;
   int seed = 32'h9834AD84;
   always #2 clk = ~clk;
   core_side_model i_core_side_model (.clk(clk), .cmd(cmd), .limit_we(limit_we), .req(req));
   addr_gen_stack_check i_addr_gen_stack_check (.clk(clk), .rst(rst), .req(req), .pc(pc),
      .status_low_byte(slb), .wr_we(wr_we), .wr_idx(wr_idx), .wr_data(wr_data),
      .limit_we(limit_we), .limit_data(limit_data), .rsp(rsp), .stack_limit_reg(lim),
      .stack_pointer_reg(sp), .stack_trap(trap));
   task automatic wrap_up();
      if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task automatic chk(string n, logic [15:0] x, logic [15:0] g);
      samples_checked++;
      if (x !== g) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   function automatic logic [15:0] ea_of(addr_gen_pkg::agen_mode_t m, logic [3:0] p,
      logic [3:0] o, logic [15:0] l);
      case (m)
         addr_gen_pkg::AM_POP: return w[15] - 16'h0002;
         addr_gen_pkg::AM_FILE: return l & 16'h1FFF;
         addr_gen_pkg::AM_PRE, addr_gen_pkg::AM_LITOFS: return w[p] + l;
         addr_gen_pkg::AM_INDEXED: return w[p] + w[o];
         addr_gen_pkg::AM_LIT5: return l & 16'h001F;
         addr_gen_pkg::AM_LIT8: return l & 16'h00FF;
         addr_gen_pkg::AM_LIT10: return l & 16'h03FF;
         addr_gen_pkg::AM_INTERRUPT_DISABLE_INSTRUCTION: return l & 16'h3FFF;
         addr_gen_pkg::AM_MOVFILE, addr_gen_pkg::AM_LIT16, addr_gen_pkg::AM_BRA: return l;
         default: return w[p];
      endcase
   endfunction : ea_of
   task automatic wr(logic [3:0] i, logic [15:0] v, logic l);
      @(negedge clk);
      cmd.valid = 1'h0;
      wr_we = ~l;
      limit_we = l;
      wr_idx = i;
      wr_data = v;
      limit_data = v;
      @(negedge clk);
      wr_we = 1'h0;
      limit_we = 1'h0;
      if (l) lm = v & 16'hFFFE;
      else w[i] = v;
   endtask : wr
   task automatic go(addr_gen_pkg::agen_mode_t m, logic [3:0] p, logic [3:0] o = 4'h0,
      logic [15:0] l = 16'h0000, addr_gen_pkg::mac_mod_t mm = addr_gen_pkg::MM_NONE);
      addr_gen_pkg::agen_req_t c;
      logic [15:0] e;
      logic [15:0] b;
      logic [3:0] xp;
      logic [3:0] yp;
      c = '0;
      c.valid = 1'h1;
      c.mode = m;
      c.ptr = p;
      c.ofs = o;
      c.lit = l;
      c.to_default_working_reg = l[15];
      c.dst = l[11:8];
      c.x_sel = p[0];
      c.y_sel = p[0];
      c.x_mod = mm;
      c.y_mod = mm;
      xp = {3'h4, p[0]};
      yp = {3'h5, p[0]};
      e = ea_of(m, p, o, l);
      b = (mm == addr_gen_pkg::MM_IDX && p[0]) ? w[o] : 16'h0000;
      @(negedge clk);
      cmd = c;
      @(posedge clk);
      #1;
      chk("base", w[o], rsp.base);
      chk("dst", {12'h000, l[15] ? 4'h0 : l[11:8]}, {12'h000, rsp.dst});
      if (m == addr_gen_pkg::AM_DIRECT ||
         (m >= addr_gen_pkg::AM_LIT5 && m <= addr_gen_pkg::AM_INTERRUPT_DISABLE_INSTRUCTION)) begin
         chk("opnd", e, rsp.opnd);
      end else if (m == addr_gen_pkg::AM_MAC) begin
         chk("x_ea", w[xp] + b, rsp.x_ea);
         chk("y_ea", w[yp] + b, rsp.y_ea);
         w[xp] = w[xp] + stp[mm];
         w[yp] = w[yp] + stp[mm];
      end else begin
         chk("ea", e, rsp.ea);
      end
      if (m == addr_gen_pkg::AM_CALL_PUSH) chk("upper", {9'h000, pc[22:16]}, rsp.push_data);
      if (m == addr_gen_pkg::AM_EXC_PUSH) chk("upper", {slb, 1'h0, pc[22:16]}, rsp.push_data);
      if (m == addr_gen_pkg::AM_POST) w[p] = w[p] + l;
      if (m == addr_gen_pkg::AM_PRE || m == addr_gen_pkg::AM_POP) w[p] = e;
      if (m inside {addr_gen_pkg::AM_PUSH, addr_gen_pkg::AM_CALL_PUSH, addr_gen_pkg::AM_EXC_PUSH})
         w[15] = e + 16'h0002;
      chk("sp", w[15], sp);
      chk("trap", {15'h0000, p == 4'hF && (e > lm || e < 16'h0800)}, {15'h0000, trap});
   endtask : go
   initial begin
      for (int i = 0; i < 16; i++) w[i] = 16'h0000;
      w[15] = 16'h0800;
      repeat (20) @(negedge clk);
      rst = 1'h0;
      wr(4'h0, 16'h0811, 1'h1);
      chk("limit", 16'h0810, lim);
      for (int i = 0; i < 10; i++) go(addr_gen_pkg::AM_PUSH, 4'hF);
      for (int i = 0; i < 11; i++) go(addr_gen_pkg::AM_POP, 4'hF);
      wr(4'hF, 16'h0900, 1'h0);
      go(addr_gen_pkg::AM_IND, 4'hF);
      wr(4'h0, 16'h0FFE, 1'h1);
      for (int i = 0; i < 4; i++) begin
         pc = 23'($random(seed));
         slb = 8'($random(seed));
         go(addr_gen_pkg::AM_CALL_PUSH, 4'hF);
         go(addr_gen_pkg::AM_EXC_PUSH, 4'hF);
      end
      // Prefetch pointers start well inside their spaces and move only a few words.
      for (int i = 8; i < 12; i++) wr(4'(i), 16'h1000 + 16'(i * 64), 1'h0);
      for (int k = 5; k < 30; k++) begin
         go(addr_gen_pkg::AM_MAC, 4'(k % 2), 4'h8, 16'h0000, addr_gen_pkg::mac_mod_t'(k % 5 + 1));
      end
      for (int k = 0; k < 260; k++) begin
         r = $random(seed);
         wr(4'(r % 15), r[31:16], 1'h0);
         r = $random(seed);
         go(addr_gen_pkg::agen_mode_t'(k % 14 + 1),
            4'(r % 15), r[7:4], r[31:16]);
      end
      wrap_up();
   end
   initial begin
      #40000;
      error_cnt++;
      wrap_up();
   end
endmodule : test_addr_gen_stack_check
bind addr_gen_stack_check addr_gen_stack_check_props i_addr_gen_stack_check_props (.clk(clk),
   .rst(rst), .req(req), .pc(pc), .status_low_byte(status_low_byte), .limit_we(limit_we),
   .limit_data(limit_data), .rsp(rsp), .stack_limit_reg(stack_limit_reg),
   .stack_pointer_reg(stack_pointer_reg), .stack_trap(stack_trap));
